// ===== design/pmc_top.sv
`timescale 1ns/10ps
module pmc_top #(
    parameter int PORT_W = 8,
    parameter int IRQ_N = 8,
    parameter int HS_STAB_NS = pmc_pkg::HS_STAB_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pmc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pmc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pmc_pkg::pmc_core_in_t core_in,
    input wire logic [IRQ_N-1:0] irq_req,
    input wire logic [IRQ_N-1:0] irq_en,
    input wire logic [PORT_W-1:0] port_a_pins,
    input wire logic wdt_enabled,
    input wire logic wdt_overflow,
    input wire logic ls_osc_stable,
    input wire logic ls_tick,
    output pmc_pkg::pmc_core_out_t core_out,
    output pmc_pkg::pmc_clk_en_t clk_en
);
    localparam int HS_STAB_CYC = (HS_STAB_NS + pmc_pkg::CLK_PERIOD_NS - 1)
        / pmc_pkg::CLK_PERIOD_NS;
    localparam logic [15:0] HS_STAB_LAST = 16'(HS_STAB_CYC - 1);

    pmc_pkg::pmc_mode_t mode_r;
    pmc_pkg::pmc_wake_t cause_r;
    pmc_pkg::pmc_core_out_t core_r;
    logic [2:0] sys_clk_sel;
    logic hs_osc_idle_en;
    logic ls_osc_idle_en;
    logic hs_osc_enable;
    logic hs_osc_stable_flag;
    logic power_down_flag;
    logic timeout_flag;
    logic [PORT_W-1:0] port_a_wake_mask;
    logic [PORT_W-1:0] port_prev_r;
    logic [IRQ_N-1:0] irq_block_r;
    logic irq_ok_r;
    logic [15:0] stab_cnt_r;
    logic hs_req;
    logic hs_en_r;
    logic ls_en_r;
    logic low_speed_rc_osc_en_r;
    logic sys_tick;
    logic div_slow;
    logic div_ready;
    logic asleep;
    logic pin_wake;
    logic irq_wake;
    logic [IRQ_N-1:0] irq_new;
    logic aw_full_r;
    logic w_full_r;
    logic [pmc_pkg::ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic w_lane0_r;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // Clock divider and source switch
    // ------------------------------------------------------------
    pmc_clk_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(sys_clk_sel),
        .run(core_r.run && !core_in.halt),
        .hs_ok(hs_osc_stable_flag),
        .ls_ok(ls_osc_stable),
        .ls_tick(ls_tick),
        .tick_r(sys_tick),
        .slow_r(div_slow),
        .ready_r(div_ready)
    );

    // ------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------
    assign asleep = (mode_r != pmc_pkg::PM_RUN)
        && (mode_r != pmc_pkg::PM_WAKE);
    assign pin_wake = |(port_prev_r & ~port_a_pins & port_a_wake_mask);
    assign irq_new = irq_req & ~irq_block_r;
    assign irq_wake = |irq_new;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_prev_r <= '0;
            irq_block_r <= '0;
        end else begin
            port_prev_r <= port_a_pins;
            if (mode_r == pmc_pkg::PM_RUN && core_in.halt) begin
                irq_block_r <= irq_req;
            end
        end
    end

    // ------------------------------------------------------------
    // Power mode sequencing
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= pmc_pkg::PM_RUN;
            cause_r <= pmc_pkg::WK_PIN;
            irq_ok_r <= 1'b0;
        end else begin
            case (mode_r)
                pmc_pkg::PM_RUN: begin
                    if (core_in.halt) begin
                        case ({hs_osc_idle_en, ls_osc_idle_en})
                            2'h0: mode_r <= pmc_pkg::PM_SLEEP;
                            2'h1: mode_r <= pmc_pkg::PM_IDLE_LOW;
                            2'h3: mode_r <= pmc_pkg::PM_IDLE_DUAL;
                            default: mode_r <= pmc_pkg::PM_IDLE_HIGH;
                        endcase
                    end
                end
                pmc_pkg::PM_WAKE: begin
                    if (div_ready) begin
                        mode_r <= pmc_pkg::PM_RUN;
                    end
                end
                default: begin
                    // Watchdog wins over interrupt, interrupt over pin
                    if (wdt_overflow) begin
                        mode_r <= pmc_pkg::PM_WAKE;
                        cause_r <= pmc_pkg::WK_WDT;
                    end else if (irq_wake) begin
                        mode_r <= pmc_pkg::PM_WAKE;
                        cause_r <= pmc_pkg::WK_IRQ;
                        irq_ok_r <= |(irq_new & irq_en)
                            && !core_in.stack_full;
                    end else if (pin_wake) begin
                        mode_r <= pmc_pkg::PM_WAKE;
                        cause_r <= pmc_pkg::WK_PIN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Core control pulses
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_r <= '0;
        end else begin
            core_r.run <= (mode_r == pmc_pkg::PM_RUN && !core_in.halt)
                || (mode_r == pmc_pkg::PM_WAKE && div_ready);
            core_r.wdt_clr <= (mode_r == pmc_pkg::PM_RUN && core_in.halt)
                || core_in.wdt_clear_instr;
            core_r.resume_next <= mode_r == pmc_pkg::PM_WAKE && div_ready
                && (cause_r == pmc_pkg::WK_PIN
                || (cause_r == pmc_pkg::WK_IRQ && !irq_ok_r));
            core_r.irq_service <= mode_r == pmc_pkg::PM_WAKE && div_ready
                && cause_r == pmc_pkg::WK_IRQ && irq_ok_r;
            core_r.pc_sp_reset <= mode_r == pmc_pkg::PM_WAKE && div_ready
                && cause_r == pmc_pkg::WK_WDT;
        end
    end

    // ------------------------------------------------------------
    // Status flags, hardware set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_flag <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            if (mode_r == pmc_pkg::PM_RUN && core_in.halt) begin
                power_down_flag <= 1'b1;
            end else if (core_in.wdt_clear_instr) begin
                power_down_flag <= 1'b0;
            end
            if (wdt_overflow) begin
                timeout_flag <= 1'b1;
            end else if (mode_r == pmc_pkg::PM_RUN && core_in.halt) begin
                timeout_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator gating
    // ------------------------------------------------------------
    always_comb begin
        case (mode_r)
            pmc_pkg::PM_SLEEP: hs_req = 1'b0;
            pmc_pkg::PM_IDLE_LOW: hs_req = 1'b0;
            pmc_pkg::PM_IDLE_DUAL: hs_req = 1'b1;
            pmc_pkg::PM_IDLE_HIGH: hs_req = 1'b1;
            default: hs_req = !div_slow || hs_osc_enable
                || sys_clk_sel != pmc_pkg::SEL_SLOW;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stab_cnt_r <= 16'h0000;
            hs_osc_stable_flag <= 1'b0;
        end else if (!hs_req) begin
            stab_cnt_r <= 16'h0000;
            hs_osc_stable_flag <= 1'b0;
        end else if (!hs_osc_stable_flag) begin
            stab_cnt_r <= stab_cnt_r + 16'h0001;
            hs_osc_stable_flag <= (stab_cnt_r == HS_STAB_LAST);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_en_r <= 1'b0;
            ls_en_r <= 1'b0;
            low_speed_rc_osc_en_r <= 1'b0;
        end else begin
            hs_en_r <= hs_req;
            ls_en_r <= mode_r != pmc_pkg::PM_SLEEP
                && mode_r != pmc_pkg::PM_IDLE_HIGH;
            low_speed_rc_osc_en_r <= mode_r != pmc_pkg::PM_SLEEP || wdt_enabled;
        end
    end

    assign core_out = core_r;
    assign clk_en = '{sys_tick: sys_tick, slow: div_slow, hs_en: hs_en_r,
        ls_en: ls_en_r, low_speed_rc_osc_en: low_speed_rc_osc_en_r};

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
    assign wr_hit = aw_addr_r == pmc_pkg::OFF_CLK_CTRL
        || aw_addr_r == pmc_pkg::OFF_HS_CTRL
        || aw_addr_r == pmc_pkg::OFF_STATUS
        || aw_addr_r == pmc_pkg::OFF_WAKE_MASK;
    assign rd_hit = s_axi_araddr == pmc_pkg::OFF_CLK_CTRL
        || s_axi_araddr == pmc_pkg::OFF_HS_CTRL
        || s_axi_araddr == pmc_pkg::OFF_STATUS
        || s_axi_araddr == pmc_pkg::OFF_WAKE_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h00000000;
            w_lane0_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pmc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_full_r) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_lane0_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_full_r) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? pmc_pkg::RESP_OKAY
                    : pmc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
            end
        end
    end

    // Writable fields; status is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_clk_sel <= pmc_pkg::SEL_RST;
            hs_osc_idle_en <= 1'b0;
            ls_osc_idle_en <= 1'b0;
            hs_osc_enable <= pmc_pkg::HS_EN_RST;
            port_a_wake_mask <= '0;
        end else if (wr_go && w_lane0_r) begin
            if (aw_addr_r == pmc_pkg::OFF_CLK_CTRL) begin
                sys_clk_sel <= w_data_r[pmc_pkg::SEL_MSB:pmc_pkg::SEL_LSB];
                hs_osc_idle_en <= w_data_r[pmc_pkg::HS_IDLE_BIT];
                ls_osc_idle_en <= w_data_r[pmc_pkg::LS_IDLE_BIT];
            end
            if (aw_addr_r == pmc_pkg::OFF_HS_CTRL) begin
                hs_osc_enable <= w_data_r[pmc_pkg::HS_EN_BIT];
            end
            if (aw_addr_r == pmc_pkg::OFF_WAKE_MASK) begin
                port_a_wake_mask <= w_data_r[PORT_W-1:0];
            end
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            pmc_pkg::OFF_CLK_CTRL: begin
                rd_word[pmc_pkg::SEL_MSB:pmc_pkg::SEL_LSB] = sys_clk_sel;
                rd_word[pmc_pkg::HS_IDLE_BIT] = hs_osc_idle_en;
                rd_word[pmc_pkg::LS_IDLE_BIT] = ls_osc_idle_en;
            end
            pmc_pkg::OFF_HS_CTRL: begin
                rd_word[pmc_pkg::HS_STABLE_BIT] = hs_osc_stable_flag;
                rd_word[pmc_pkg::HS_EN_BIT] = hs_osc_enable;
            end
            pmc_pkg::OFF_STATUS: begin
                rd_word[pmc_pkg::PDF_BIT] = power_down_flag;
                rd_word[pmc_pkg::TO_BIT] = timeout_flag;
                rd_word[pmc_pkg::SLOW_BIT] = div_slow;
                rd_word[pmc_pkg::RUN_BIT] = core_r.run;
            end
            pmc_pkg::OFF_WAKE_MASK: rd_word[PORT_W-1:0] = port_a_wake_mask;
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pmc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? pmc_pkg::RESP_OKAY
                : pmc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ===== design/pmc_pkg.sv
package pmc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_HS_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_WAKE_MASK = 8'h0C;

    // Field positions
    localparam int SEL_LSB = 5;
    localparam int SEL_MSB = 7;
    localparam int HS_IDLE_BIT = 1;
    localparam int LS_IDLE_BIT = 0;
    localparam int HS_STABLE_BIT = 1;
    localparam int HS_EN_BIT = 0;
    localparam int PDF_BIT = 0;
    localparam int TO_BIT = 1;
    localparam int SLOW_BIT = 2;
    localparam int RUN_BIT = 3;

    // Reset values and slow clock select code
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic HS_EN_RST = 1'b1;
    localparam logic [2:0] SEL_SLOW = 3'h7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // High-speed oscillator settle time
    localparam int CLK_PERIOD_NS = 50;
    localparam int HS_STAB_NS = 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PM_RUN,
        PM_SLEEP,
        PM_IDLE_LOW,
        PM_IDLE_DUAL,
        PM_IDLE_HIGH,
        PM_WAKE
    } pmc_mode_t;

    typedef enum logic [1:0] {
        WK_PIN,
        WK_IRQ,
        WK_WDT
    } pmc_wake_t;

    typedef struct packed {
        logic halt;
        logic wdt_clear_instr;
        logic stack_full;
    } pmc_core_in_t;

    typedef struct packed {
        logic run;
        logic resume_next;
        logic irq_service;
        logic pc_sp_reset;
        logic wdt_clr;
    } pmc_core_out_t;

    typedef struct packed {
        logic sys_tick;
        logic slow;
        logic hs_en;
        logic ls_en;
        logic low_speed_rc_osc_en;
    } pmc_clk_en_t;
endpackage

// ===== design/pmc_clk_div.sv
`timescale 1ns/10ps
module pmc_clk_div (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] sel,
    input wire logic run,
    input wire logic hs_ok,
    input wire logic ls_ok,
    input wire logic ls_tick,
    output logic tick_r,
    output logic slow_r,
    output logic ready_r
);
    logic [2:0] cur_r;
    logic [5:0] cnt_r;
    logic [5:0] mask;
    logic bound;
    logic tgt_ok;

    assign mask = 6'((7'h01 << cur_r) - 7'h01);
    assign bound = slow_r ? ls_tick : (cnt_r == mask);
    assign tgt_ok = (sel == pmc_pkg::SEL_SLOW) ? ls_ok : hs_ok;

    // ------------------------------------------------------------
    // Source switch only at a period boundary, so no runt pulse
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_r <= pmc_pkg::SEL_RST;
            slow_r <= 1'b0;
            cnt_r <= 6'h00;
        end else if (bound && sel != cur_r && tgt_ok) begin
            cur_r <= sel;
            slow_r <= (sel == pmc_pkg::SEL_SLOW);
            cnt_r <= 6'h00;
        end else if (bound || slow_r) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            tick_r <= run && bound;
            ready_r <= slow_r ? ls_ok : hs_ok;
        end
    end
endmodule

// ===== tb/pmc_far_model.sv
`timescale 1ns/10ps
module pmc_far_model #(
    parameter int LS_DIV = 10,
    parameter int LS_SETTLE = 30
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic low_speed_rc_osc_en,
    output logic ls_tick,
    output logic ls_osc_stable
);
    // ------------
    // Low-speed oscillator stand-in
    // ------------
    int div_r;
    int settle_r;
    // Ticks stop while the oscillator is gated off
    always_ff @(posedge aclk) begin
        if (!aresetn || !low_speed_rc_osc_en) begin
            div_r <= 0;
            ls_tick <= 1'b0;
        end else begin
            ls_tick <= (div_r == LS_DIV - 1);
            div_r <= (div_r == LS_DIV - 1) ? 0 : div_r + 1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= 0;
        end else if (settle_r < LS_SETTLE) begin
            settle_r <= settle_r + 1;
        end
    end
    assign ls_osc_stable = (settle_r == LS_SETTLE);
endmodule

// ===== tb/pmc_top_assertions.sv
`timescale 1ns/10ps
module pmc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pmc_pkg::pmc_core_in_t core_in,
    input wire logic wdt_enabled,
    input wire logic ls_osc_stable,
    input wire pmc_pkg::pmc_core_out_t core_out,
    input wire pmc_pkg::pmc_clk_en_t clk_en
);
    // ------------
    // Helpers
    // ------------
    logic halted_r;
    logic wake_any;
    logic off_both;
    assign wake_any = core_out.resume_next | core_out.irq_service
        | core_out.pc_sp_reset;
    assign off_both = !core_out.run && !clk_en.hs_en && !clk_en.ls_en;
    // Run rising after reset is no wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halted_r <= 1'b0;
        end else if (core_in.halt && core_out.run) begin
            halted_r <= 1'b1;
        end else if (core_out.run) begin
            halted_r <= 1'b0;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------
    // Properties
    // ------------
    a_halt_stops_run: assert property (
        core_in.halt && core_out.run |=> !core_out.run [*2])
        else $error("run after halt");
    a_halt_clears_wdt: assert property (
        core_in.halt && core_out.run |=> core_out.wdt_clr)
        else $error("no wdt clear");
    a_wdt_clr_cause: assert property (
        core_out.wdt_clr |-> $past(core_in.halt && core_out.run)
            || $past(core_in.wdt_clear_instr))
        else $error("stray wdt clear");
    a_wake_one_cause: assert property (
        $rose(core_out.run) && halted_r |-> $onehot({core_out.resume_next,
            core_out.irq_service, core_out.pc_sp_reset}))
        else $error("wake kind");
    a_pulse_at_wake: assert property (
        wake_any |-> $rose(core_out.run) && halted_r)
        else $error("stray restart");
    a_pulse_single: assert property (
        wake_any |=> !wake_any)
        else $error("long restart");
    a_tick_needs_run: assert property (
        clk_en.sys_tick |-> core_out.run)
        else $error("tick stopped");
    a_sleep_low_speed_rc_osc: assert property (
        $past(aresetn) && off_both && $past(off_both)
            |-> clk_en.low_speed_rc_osc_en == wdt_enabled)
        else $error("sleep low_speed_rc_osc");
    a_slow_stable: assert property (
        $rose(clk_en.slow) |-> $past(ls_osc_stable))
        else $error("slow unstable");
endmodule
bind pmc_top pmc_checker u_pmc_checker (.aclk, .aresetn, .core_in,
    .wdt_enabled, .ls_osc_stable, .core_out, .clk_en);

// ===== tb/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
    end end
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic wdt_enabled, wdt_overflow, ls_osc_stable, ls_tick;
    logic [7:0] s_axi_awaddr, s_axi_araddr, irq_req, irq_en, port_a_pins;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [33:0] v;
    logic [7:0] lfsr_r = 8'h34;
    logic [2:0] sel;
    pmc_pkg::pmc_core_in_t core_in;
    pmc_pkg::pmc_core_out_t core_out;
    pmc_pkg::pmc_clk_en_t clk_en;
    int mismatches = 0;
    int num_checks = 0;
    int i, g;
    pmc_top #(.HS_STAB_NS(1000)) u_pmc_top (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .core_in, .irq_req, .irq_en, .port_a_pins,
        .wdt_enabled, .wdt_overflow, .ls_osc_stable, .ls_tick,
        .core_out, .clk_en);
    pmc_far_model u_pmc_far_model (.aclk, .aresetn,
        .low_speed_rc_osc_en(clk_en.low_speed_rc_osc_en), .ls_tick, .ls_osc_stable);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ------------
    // Helpers and bus tasks
    // ------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [33:0] st(input logic [3:0] b);
        return {pmc_pkg::RESP_OKAY, 28'h0, b};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo();
        mismatches++;
        final_report();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) tmo();
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = {s_axi_rresp, s_axi_rdata};
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) tmo();
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic x);
        int n;
        for (n = 0; n < 60; n++) begin
            axr(a);
            if (v[b] === x) break;
        end
        if (n == 60) tmo();
    endtask
    task automatic halt_core();
        @(posedge aclk);
        core_in.halt <= 1'b1;
        @(posedge aclk);
        core_in.halt <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic wake_exp(input logic [2:0] e);
        int n;
        for (n = 0; n < 200 && core_out.run !== 1'b1; n++) @(posedge aclk);
        if (n == 200) tmo();
        `CHK("wake kind", e, {core_out.resume_next, core_out.irq_service,
            core_out.pc_sp_reset})
    endtask
    task automatic tick_gap();
        int n;
        for (n = 0; n < 400 && !clk_en.sys_tick; n++) @(negedge aclk);
        @(negedge aclk);
        for (g = 1; g < 400 && !clk_en.sys_tick; g++) @(negedge aclk);
    endtask
    // ------------
    // Main sequence
    // ------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, wdt_overflow, irq_req} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_en} = '0;
        {core_in, wdt_enabled} = '0;
        s_axi_wstrb = 4'hF;
        port_a_pins = 8'hFF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axr(pmc_pkg::OFF_HS_CTRL);
        `CHK("hs ctrl early", st(4'h1), v)
        axr(pmc_pkg::OFF_CLK_CTRL);
        `CHK("clk ctrl rst", st(4'h0), v)
        axr(pmc_pkg::OFF_STATUS);
        `CHK("status rst", st(4'h8), v)
        axr(8'h10);
        `CHK("unmapped rd", {pmc_pkg::RESP_SLVERR, 32'h0}, v)
        axw(8'h14, 32'hFF);
        `CHK("unmapped wr", pmc_pkg::RESP_SLVERR, r)
        s_axi_wstrb <= 4'hE;
        axw(pmc_pkg::OFF_CLK_CTRL, 32'hE0);
        s_axi_wstrb <= 4'hF;
        axr(pmc_pkg::OFF_CLK_CTRL);
        `CHK("strobe off", st(4'h0), v)
        $display("test registers done");
        // Idle codes, pin wake
        for (i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wdt_enabled <= lfsr_r[0];
            sel = {i[1], i[1] ^ i[0]};
            axw(pmc_pkg::OFF_CLK_CTRL, {30'h0, sel[1:0]});
            axw(pmc_pkg::OFF_WAKE_MASK, 32'h1 << i);
            @(posedge aclk);
            wdt_overflow <= 1'b1;
            @(posedge aclk);
            wdt_overflow <= 1'b0;
            halt_core();
            @(negedge aclk);
            `CHK("osc enables", sel[1:0], {clk_en.hs_en, clk_en.ls_en})
            axr(pmc_pkg::OFF_STATUS);
            `CHK("halt status", st(4'h1), v)
            port_a_pins <= ~(8'h02 << i);
            repeat (8) @(posedge aclk);
            `CHK("masked pin", 1'b0, core_out.run)
            port_a_pins <= ~(8'h01 << i);
            wake_exp(3'b100);
            port_a_pins <= 8'hFF;
            @(posedge aclk);
            core_in.wdt_clear_instr <= 1'b1;
            @(posedge aclk);
            core_in.wdt_clear_instr <= 1'b0;
            axr(pmc_pkg::OFF_STATUS);
            `CHK("pdf cleared", st(4'h8), v)
        end
        $display("test idle modes done");
        // Irq wake: on, stack full, off
        for (i = 0; i < 3; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            irq_en <= (i == 2) ? 8'h00 : 8'hFF;
            core_in.stack_full <= (i == 1);
            halt_core();
            irq_req <= 8'h01 << lfsr_r[2:0];
            wake_exp((i == 0) ? 3'b010 : 3'b100);
            irq_req <= (i == 2) ? 8'h01 : 8'h00;
        end
        halt_core();
        repeat (10) @(posedge aclk);
        `CHK("pending irq", 1'b0, core_out.run)
        wdt_overflow <= 1'b1;
        @(posedge aclk);
        wdt_overflow <= 1'b0;
        wake_exp(3'b001);
        irq_req <= 8'h00;
        axr(pmc_pkg::OFF_STATUS);
        `CHK("wdt wake status", st(4'hB), v)
        $display("test wake sources done");
        // Divider, slow, fast return
        for (i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            sel = lfsr_r[2:0] % 7;
            axw(pmc_pkg::OFF_CLK_CTRL, {24'h0, sel, 5'h0});
            repeat (3) tick_gap();
            `CHK("fast gap", 1 << sel, g)
        end
        axw(pmc_pkg::OFF_CLK_CTRL, {24'h0, pmc_pkg::SEL_SLOW, 5'h0});
        poll(pmc_pkg::OFF_STATUS, pmc_pkg::SLOW_BIT, 1'b1);
        repeat (2) tick_gap();
        `CHK("slow gap", 10, g)
        axw(pmc_pkg::OFF_HS_CTRL, 32'h0);
        axw(pmc_pkg::OFF_HS_CTRL, 32'h1);
        axr(pmc_pkg::OFF_HS_CTRL);
        `CHK("stable restart", st(4'h1), v)
        poll(pmc_pkg::OFF_HS_CTRL, pmc_pkg::HS_STABLE_BIT, 1'b1);
        axw(pmc_pkg::OFF_CLK_CTRL, 32'h60);
        poll(pmc_pkg::OFF_STATUS, pmc_pkg::SLOW_BIT, 1'b0);
        repeat (3) tick_gap();
        `CHK("fast return gap", 8, g)
        $display("test clock switching done");
        final_report();
    end
endmodule
